// file: hw/bbce_map.vh
// opcode, field and timing constants for the bit, branch, call and clear slice
`ifndef BBCE_MAP_VH
`define BBCE_MAP_VH

// opcode patterns
`define BBCE_OP_TOGGLE      4'h7
`define BBCE_OP_BR_OVF      8'hE4
`define BBCE_OP_BR_EQUAL    8'hE0
`define BBCE_OP_CALL        7'h76
`define BBCE_OP_CALL2       4'hF
`define BBCE_OP_CLEAR       7'h35
`define BBCE_OP_CLEAR_DOG   16'h0004
`define BBCE_OP_COMPLEMENT  6'h07

// field positions
`define BBCE_FLD_BIT_HI     11
`define BBCE_FLD_BIT_LO     9
`define BBCE_FLD_DEST       9
`define BBCE_FLD_ACCESS     8
`define BBCE_FLD_SAVE       8

// flag positions in the status byte
`define BBCE_FLAG_ZERO      2
`define BBCE_FLAG_OVF       3
`define BBCE_FLAG_SIGN      4

// reset values and geometry
`define BBCE_PC_RESET       21'h000000
`define BBCE_PC_STEP        21'h000002
`define BBCE_ACCESS_SPLIT   8'h80
`define BBCE_ACCESS_HI_BANK 4'hF
`define BBCE_ACCESS_LO_BANK 4'h0
`define BBCE_BYTE_ZERO      8'h00
`define BBCE_FLAGS_RESET    5'h00

// every operation of this slice is one instruction cycle per word, except a taken branch, which takes two
`define BBCE_CYCLES_BASIC   1
`define BBCE_CYCLES_TAKEN   2

`endif

// file: hw/bbce_data_mem.v
// banked data memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module bbce_data_mem #(
  parameter AW = 12,
  parameter DW = 8
) (
  // clock
  input  wire          i_clk,
  // write port
  input  wire          i_wr_en,
  input  wire [AW-1:0] i_wr_addr,
  input  wire [DW-1:0] i_wr_data,
  // read port
  input  wire [AW-1:0] i_rd_addr,
  output reg  [DW-1:0] o_rd_data
);

  reg [DW-1:0] mem_reg [0:(1<<AW)-1];

  // read returns old data on a same-address write; caller forwards
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_reg[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem_reg[i_rd_addr];
  end

endmodule // bbce_data_mem
`default_nettype wire

// file: hw/bbce_exec.v
// execute slice: bit toggle, flag branches, call, clears, complement
//
// What this block does
// RULE1 - bit toggle inverts only the selected bit
// RULE2 - access bit zero selects access bank
// RULE3 - overflow branch taken only on overflow; flags kept
// RULE4 - taken target is address plus two plus 2n
// RULE5 - branch one cycle, taken two with idle second
// RULE6 - equal branch taken only on zero; flags kept
// RULE7 - call two words, 20-bit target into pc
// RULE8 - call pushes address plus four; optional shadow save
// RULE9 - clear writes zero and sets zero flag
// RULE10 - clear dog resets counter and postscaler
// RULE11 - clear dog sets expiry and sleep flags
// RULE12 - complement inverts data, updates sign and zero
// RULE13 - complement destination: accumulator or source register
// RULE14 - redirect discards the prefetched word
// RULE15 - call without save leaves shadows alone
`timescale 1ns/100ps
`default_nettype none
`include "bbce_map.vh"
module bbce_exec #(
  parameter PCW = 21,
  parameter AW  = 12
) (
  // clock and reset
  input  wire           i_clk,
  input  wire           i_srst,
  // program fetch
  input  wire [15:0]    i_instr,
  output reg  [PCW-1:0] o_pc_reg,
  // state owned by the rest of the core
  input  wire [3:0]     i_bank_select,
  input  wire           i_acc_wr,
  input  wire [7:0]     i_acc_data,
  input  wire           i_flags_wr,
  input  wire [4:0]     i_flags_data,
  input  wire           i_dog_timeout,
  input  wire           i_sleep_entry,
  // visible state
  output reg  [7:0]     o_acc_reg,
  output reg  [4:0]     o_flags_reg,
  output reg            o_expiry_flag_reg,
  output reg            o_sleep_flag_reg,
  // watchdog and stack
  output reg            o_dog_clear_reg,
  output reg            o_push_reg,
  output reg  [PCW-1:0] o_push_addr_reg,
  // shadows
  output reg  [7:0]     o_acc_shadow_reg,
  output reg  [4:0]     o_flags_shadow_reg,
  output reg  [3:0]     o_bank_shadow_reg
);

  function [AW-1:0] bank_addr;
    input       acc_bit;
    input [7:0] f;
    input [3:0] bank;
    begin
      if (acc_bit) begin
        bank_addr = {bank, f}; // see RULE2
      end else if (f < `BBCE_ACCESS_SPLIT) begin
        bank_addr = {`BBCE_ACCESS_LO_BANK, f}; // see RULE2
      end else begin
        bank_addr = {`BBCE_ACCESS_HI_BANK, f}; // see RULE2
      end
    end
  endfunction

  function [PCW-1:0] branch_target;
    input [PCW-1:0] pc;
    input [7:0]     n;
    begin
      // pc already points past the branch, so this is branch + 2 + 2n
      branch_target = pc + {{(PCW-9){n[7]}}, n, 1'b0}; // see RULE4
    end
  endfunction

  // pipeline state
  reg           valid_reg;
  reg           valid_next;
  reg  [15:0]   instr_reg;
  reg  [AW-1:0] ex_addr_reg;
  reg  [PCW-1:0] pc_next;
  reg  [7:0]    acc_next;
  reg  [4:0]    flags_next;
  reg           expiry_next;
  reg           sleep_next;
  reg           dog_clear_next;
  reg           push_next;
  reg  [PCW-1:0] push_addr_next;
  reg  [7:0]    acc_sh_next;
  reg  [4:0]    flags_sh_next;
  reg  [3:0]    bank_sh_next;
  reg           wr_en;
  reg  [7:0]    wr_data;
  reg           last_wr_reg;
  reg  [AW-1:0] last_addr_reg;
  reg  [7:0]    last_data_reg;
  wire [7:0]    mem_rd;
  wire [7:0]    rd_data;
  wire [7:0]    comp_val;
  wire [AW-1:0] fetch_addr;

  wire is_toggle = instr_reg[15:12] == `BBCE_OP_TOGGLE;
  wire is_br_ovf = instr_reg[15:8] == `BBCE_OP_BR_OVF;
  wire is_br_eq  = instr_reg[15:8] == `BBCE_OP_BR_EQUAL;
  wire is_call   = instr_reg[15:9] == `BBCE_OP_CALL;
  wire is_clear  = instr_reg[15:9] == `BBCE_OP_CLEAR;
  wire is_dog    = instr_reg == `BBCE_OP_CLEAR_DOG;
  wire is_comp   = instr_reg[15:10] == `BBCE_OP_COMPLEMENT;

  // operand address is formed while the word is still being fetched
  assign fetch_addr = bank_addr(i_instr[`BBCE_FLD_ACCESS], i_instr[7:0], i_bank_select);
  // write of the previous cycle is not yet visible in the read register
  assign rd_data  = (last_wr_reg && last_addr_reg == ex_addr_reg) ? last_data_reg : mem_rd;
  assign comp_val = ~rd_data;

  bbce_data_mem #(
    .AW (AW),
    .DW (8)
  ) u_mem (
    .i_clk     (i_clk),
    .i_wr_en   (wr_en),
    .i_wr_addr (ex_addr_reg),
    .i_wr_data (wr_data),
    .i_rd_addr (fetch_addr),
    .o_rd_data (mem_rd)
  );

  always @* begin
    pc_next        = o_pc_reg + `BBCE_PC_STEP;
    valid_next     = 1'b1;
    acc_next       = i_acc_wr ? i_acc_data : o_acc_reg;
    flags_next     = i_flags_wr ? i_flags_data : o_flags_reg;
    expiry_next    = i_dog_timeout ? 1'b0 : o_expiry_flag_reg;
    sleep_next     = i_sleep_entry ? 1'b0 : o_sleep_flag_reg;
    dog_clear_next = 1'b0;
    push_next      = 1'b0;
    push_addr_next = o_push_addr_reg;
    acc_sh_next    = o_acc_shadow_reg;
    flags_sh_next  = o_flags_shadow_reg;
    bank_sh_next   = o_bank_shadow_reg;
    wr_en          = 1'b0;
    wr_data        = rd_data;
    if (valid_reg) begin
      if (is_toggle) begin
        wr_en   = 1'b1;
        wr_data = rd_data ^ (8'h01 << instr_reg[`BBCE_FLD_BIT_HI:`BBCE_FLD_BIT_LO]); // see RULE1
      end else if ((is_br_ovf && o_flags_reg[`BBCE_FLAG_OVF]) ||
                   (is_br_eq && o_flags_reg[`BBCE_FLAG_ZERO])) begin // see RULE3 RULE6
        pc_next    = branch_target(o_pc_reg, instr_reg[7:0]); // see RULE4
        valid_next = 1'b0; // see RULE5 RULE14
      end else if (is_call) begin
        // second word is on the fetch bus this very cycle
        pc_next        = {i_instr[11:0], instr_reg[7:0], 1'b0}; // see RULE7
        valid_next     = 1'b0; // see RULE14
        push_next      = 1'b1;
        push_addr_next = o_pc_reg + `BBCE_PC_STEP; // see RULE8
        if (instr_reg[`BBCE_FLD_SAVE]) begin // see RULE15
          acc_sh_next   = o_acc_reg; // see RULE8
          flags_sh_next = o_flags_reg;
          bank_sh_next  = i_bank_select;
        end
      end else if (is_clear) begin
        wr_en                         = 1'b1;
        wr_data                       = `BBCE_BYTE_ZERO; // see RULE9
        flags_next[`BBCE_FLAG_ZERO]   = 1'b1;
      end else if (is_dog) begin
        dog_clear_next = 1'b1; // see RULE10
        expiry_next    = 1'b1; // see RULE11
        sleep_next     = 1'b1;
      end else if (is_comp) begin
        flags_next[`BBCE_FLAG_SIGN] = comp_val[7]; // see RULE12
        flags_next[`BBCE_FLAG_ZERO] = comp_val == `BBCE_BYTE_ZERO;
        if (instr_reg[`BBCE_FLD_DEST]) begin
          wr_en   = 1'b1; // see RULE13
          wr_data = comp_val;
        end else begin
          acc_next = comp_val; // see RULE13
        end
      end
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_pc_reg           <= `BBCE_PC_RESET;
      valid_reg          <= 1'b0;
      instr_reg          <= 16'h0000;
      ex_addr_reg        <= {AW{1'b0}};
      o_acc_reg          <= `BBCE_BYTE_ZERO;
      o_flags_reg        <= `BBCE_FLAGS_RESET;
      o_expiry_flag_reg  <= 1'b1;
      o_sleep_flag_reg   <= 1'b1;
      o_dog_clear_reg    <= 1'b0;
      o_push_reg         <= 1'b0;
      o_push_addr_reg    <= `BBCE_PC_RESET;
      o_acc_shadow_reg   <= `BBCE_BYTE_ZERO;
      o_flags_shadow_reg <= `BBCE_FLAGS_RESET;
      o_bank_shadow_reg  <= 4'h0;
      last_wr_reg        <= 1'b0;
      last_addr_reg      <= {AW{1'b0}};
      last_data_reg      <= `BBCE_BYTE_ZERO;
    end else begin
      o_pc_reg           <= pc_next;
      valid_reg          <= valid_next;
      instr_reg          <= i_instr;
      ex_addr_reg        <= fetch_addr;
      o_acc_reg          <= acc_next;
      o_flags_reg        <= flags_next;
      o_expiry_flag_reg  <= expiry_next;
      o_sleep_flag_reg   <= sleep_next;
      o_dog_clear_reg    <= dog_clear_next;
      o_push_reg         <= push_next;
      o_push_addr_reg    <= push_addr_next;
      o_acc_shadow_reg   <= acc_sh_next;
      o_flags_shadow_reg <= flags_sh_next;
      o_bank_shadow_reg  <= bank_sh_next;
      last_wr_reg        <= wr_en;
      last_addr_reg      <= ex_addr_reg;
      last_data_reg      <= wr_data;
    end
  end

endmodule // bbce_exec
`default_nettype wire

// file: sim/bbce_exec_props.sv
// assertion checker for the execute slice
`timescale 1ns/100ps
`default_nettype none
module bbce_exec_chk #(
  parameter PCW = 21
) (
  // clock, reset, fetch
  input wire logic           i_clk,
  input wire logic           i_srst,
  input wire logic [15:0]    i_instr,
  input wire logic [PCW-1:0] o_pc_reg,
  // state
  input wire logic [7:0]     o_acc_reg,
  input wire logic [4:0]     o_flags_reg,
  input wire logic           i_acc_wr,
  input wire logic           i_flags_wr,
  input wire logic           o_expiry_flag_reg,
  input wire logic           o_sleep_flag_reg,
  input wire logic           o_dog_clear_reg,
  input wire logic           o_push_reg,
  input wire logic [PCW-1:0] o_push_addr_reg,
  input wire logic [7:0]     o_acc_shadow_reg,
  input wire logic [4:0]     o_flags_shadow_reg
);
  logic [15:0]    w;
  logic           v;
  logic           k;
  wire            live = v && !k;
  wire            brz = (w[15:8] == 8'hE0);
  wire            brv = (w[15:8] == 8'hE4);
  wire            tkn = (brz && o_flags_reg[2]) || (brv && o_flags_reg[3]);
  wire            cal = (w[15:9] == 7'h76);
  wire [PCW-1:0]  tgt = o_pc_reg + {{(PCW-9){w[7]}}, w[7:0], 1'b0};
  wire [PCW-1:0]  ctg = {i_instr[11:0], w[7:0], 1'b0};
  // k marks the word fetched while a redirect executes
  always @(posedge i_clk) begin
    w <= i_instr;
    v <= !i_srst;
    k <= !i_srst && live && (tkn || cal);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  property p_tkn;
    live && tkn |=> o_pc_reg == $past(tgt);
  endproperty
  a_tkn: assert property (p_tkn) else $error("taken target wrong");
  property p_nt;
    live && (brz || brv) && !tkn |=> o_pc_reg == $past(o_pc_reg) + 2;
  endproperty
  a_nt: assert property (p_nt) else $error("untaken branch moved pc");
  property p_fl;
    live && (brz || brv) && !i_flags_wr |=> $stable(o_flags_reg);
  endproperty
  a_fl: assert property (p_fl) else $error("branch changed flags");
  property p_cal;
    live && cal |=> o_pc_reg == $past(ctg) && o_push_reg &&
      o_push_addr_reg == $past(o_pc_reg) + 2;
  endproperty
  a_cal: assert property (p_cal) else $error("call target or push wrong");
  property p_sh;
    live && cal && w[8] |=> o_acc_shadow_reg == $past(o_acc_reg) &&
      o_flags_shadow_reg == $past(o_flags_reg);
  endproperty
  a_sh: assert property (p_sh) else $error("shadow not saved");
  property p_nsh;
    live && cal && !w[8] |=> $stable(o_acc_shadow_reg) && $stable(o_flags_shadow_reg);
  endproperty
  a_nsh: assert property (p_nsh) else $error("shadow changed");
  property p_dog;
    // a second clear right behind the first pulses again; that word is $past(w) here
    live && w == 16'h0004 |=> o_dog_clear_reg && o_expiry_flag_reg && o_sleep_flag_reg
      ##1 (!o_dog_clear_reg || $past(w) == 16'h0004);
  endproperty
  a_dog: assert property (p_dog) else $error("watchdog clear wrong");
  property p_bub;
    k && !i_acc_wr && !i_flags_wr |=>
      $stable(o_acc_reg) && $stable(o_flags_reg) && !o_push_reg;
  endproperty
  a_bub: assert property (p_bub) else $error("discarded word had effect");
  c_tkn: cover property (live && tkn);
  c_cal: cover property (live && cal && w[8]);
  c_dog: cover property (o_dog_clear_reg);
endmodule // bbce_exec_chk
bind bbce_exec bbce_exec_chk #(.PCW(PCW)) u_chk (.i_clk, .i_srst, .i_instr, .o_pc_reg, .o_acc_reg,
  .o_flags_reg, .i_acc_wr, .i_flags_wr, .o_expiry_flag_reg, .o_sleep_flag_reg, .o_dog_clear_reg,
  .o_push_reg, .o_push_addr_reg, .o_acc_shadow_reg, .o_flags_shadow_reg);
`default_nettype wire

// file: sim/test_bbce_exec.sv
// self-checking bench for the execute slice
`timescale 1ns/100ps
`default_nettype none
module test_bbce_exec;
  logic        i_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [15:0] i_instr = 16'h0000;
  logic [3:0]  i_bank_select = 4'h0;
  logic        i_acc_wr = 1'b0;
  logic [7:0]  i_acc_data = 8'h5A;
  logic        i_flags_wr = 1'b0;
  logic [4:0]  i_flags_data = 5'h00;
  logic        i_dog_timeout = 1'b0;
  logic        i_sleep_entry = 1'b0;
  wire  [20:0] o_pc_reg, o_push_addr_reg;
  wire  [7:0]  o_acc_reg, o_acc_shadow_reg;
  wire  [4:0]  o_flags_reg, o_flags_shadow_reg;
  wire  [3:0]  o_bank_shadow_reg;
  wire         o_expiry_flag_reg, o_sleep_flag_reg, o_dog_clear_reg, o_push_reg;
  logic [15:0] rom [0:255];
  integer      fails = 0;
  integer      comparisons = 0;
  bbce_exec dut (.i_clk, .i_srst, .i_instr, .o_pc_reg, .i_bank_select, .i_acc_wr, .i_acc_data,
    .i_flags_wr, .i_flags_data, .i_dog_timeout, .i_sleep_entry, .o_acc_reg, .o_flags_reg,
    .o_expiry_flag_reg, .o_sleep_flag_reg, .o_dog_clear_reg, .o_push_reg, .o_push_addr_reg,
    .o_acc_shadow_reg, .o_flags_shadow_reg, .o_bank_shadow_reg);
  always #20 i_clk = ~i_clk;
  // rom answers the fetch address half a cycle later
  always @(negedge i_clk) i_instr <= rom[o_pc_reg[8:1]];
  // wide enough for the longest concatenation that is compared
  task chk(input [63:0] g, input [63:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // load program, reset, preload acc/flags and pulse dog/sleep at first edge, run n edges
  task run(input [15:0] a, b, c, d, e, input [4:0] fl, input integer n);
    integer j;
    begin
      for (j = 0; j < 256; j = j + 1) rom[j] = 16'h0000;
      rom[0] = a;
      rom[1] = b;
      rom[2] = c;
      rom[3] = d;
      rom[4] = e;
      i_srst = 1'b1;
      repeat (2) @(negedge i_clk);
      {i_srst, i_flags_wr, i_acc_wr, i_dog_timeout, i_sleep_entry} = 5'h0F;
      i_flags_data = fl;
      @(negedge i_clk);
      {i_flags_wr, i_acc_wr, i_dog_timeout, i_sleep_entry} = 4'h0;
      repeat (n - 1) @(negedge i_clk);
    end
  endtask
  task t_clr;
    begin
      run(16'h6A10, 16'h1E10, 16'h1C10, 16'h0000, 16'h0000, 5'h00, 2);
      chk(o_flags_reg, 5'h04);
      @(negedge i_clk);
      chk({o_acc_reg, o_flags_reg}, {8'h5A, 5'h10});
      @(negedge i_clk);
      chk({o_acc_reg, o_flags_reg}, {8'h00, 5'h04});
    end
  endtask
  task t_tog;
    begin
      i_bank_select = 4'h3;
      run(16'h6B20, 16'h6A20, 16'h7B20, 16'h1C20, 16'h1D20, 5'h00, 5);
      chk(o_acc_reg, 8'hFF);
      @(negedge i_clk);
      chk({o_acc_reg, o_flags_reg}, {8'hDF, 5'h10});
      // upper half of the access bank must land in bank F
      i_bank_select = 4'hF;
      run(16'h6B90, 16'h1E90, 16'h1D90, 16'h0000, 16'h0000, 5'h00, 4);
      chk({o_acc_reg, o_flags_reg}, {8'h00, 5'h04});
    end
  endtask
  task t_br;
    begin
      run(16'hE403, 16'h1C10, 16'h0000, 16'h0000, 16'h0000, 5'h08, 2);
      chk(o_pc_reg, 21'h000008);
      repeat (2) @(negedge i_clk);
      chk({o_acc_reg, o_flags_reg}, {8'h5A, 5'h08});
      run(16'h0000, 16'h0000, 16'hE0FE, 16'h0000, 16'h0000, 5'h04, 4);
      chk({o_pc_reg, o_flags_reg}, {21'h000002, 5'h04});
      run(16'hE405, 16'hE005, 16'h0000, 16'h0000, 16'h0000, 5'h13, 3);
      chk({o_pc_reg, o_flags_reg}, {21'h000006, 5'h13});
    end
  endtask
  task t_call;
    begin
      i_bank_select = 4'h5;
      run(16'hED34, 16'hF012, 16'h0000, 16'h0000, 16'h0000, 5'h15, 2);
      chk(o_pc_reg, 21'h002468);
      chk({o_push_reg, o_push_addr_reg}, {1'b1, 21'h000004});
      chk({o_acc_shadow_reg, o_flags_shadow_reg}, {8'h5A, 5'h15});
      chk(o_bank_shadow_reg, 4'h5);
      @(negedge i_clk);
      chk({o_push_reg, o_acc_reg}, {1'b0, 8'h5A});
      run(16'hEC34, 16'hF012, 16'h0000, 16'h0000, 16'h0000, 5'h15, 2);
      chk({o_pc_reg, o_push_reg}, {21'h002468, 1'b1});
      chk({o_acc_shadow_reg, o_flags_shadow_reg, o_bank_shadow_reg}, 17'h00000);
    end
  endtask
  task t_dog;
    begin
      run(16'h0000, 16'h0004, 16'h0000, 16'h0000, 16'h0000, 5'h0A, 2);
      chk({o_dog_clear_reg, o_expiry_flag_reg, o_sleep_flag_reg}, 3'h0);
      @(negedge i_clk);
      chk({o_dog_clear_reg, o_expiry_flag_reg, o_sleep_flag_reg}, 3'h7);
      chk(o_flags_reg, 5'h0A);
      @(negedge i_clk);
      chk(o_dog_clear_reg, 1'b0);
    end
  endtask
  task summarize;
    begin
      if (fails == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // whole run is under 70 cycles; this limit is generous
  initial begin
    #40000;
    fails = fails + 1;
    summarize;
  end
  initial begin
    repeat (16) @(negedge i_clk);
    t_clr;
    t_tog;
    t_br;
    t_call;
    t_dog;
    summarize;
  end
endmodule // test_bbce_exec
`default_nettype wire
